// ### hw/ratg_top.sv
// Command side of the random-access test generator, with Avalon-MM slave.
// Assumes firmware checks free space before each address write and that
// the controller's user clock is at or above its link clock.
// A header never runs ahead of its command; a frozen block stalls the bus.
// Functional notes
// - Queues keep only address bits 47 to 3; low three bits are zero.
// - Every firmware address enters both the command and header queues.
// - Each address queue holds 1024 entries.
// - Free-space count derives from the header queue occupancy only.
// - Pop command queue only when not empty and controller is ready.
// - Command queue falls through; its pop strobe is the command valid.
// - Header queue is popped by the data path no earlier than its command pop.
// - Sticky starvation flag sets if the controller is ready on an empty command queue during a run.
// - Completed count is issued commands minus controller pending count.
// - Only write and read commands are issued here, never single-mode.
// - For writes, header pop is one cycle when non-empty and data ready.
`timescale 1ns/100ps
module ratg_top
	import ratg_pkg::*;
(
	input wire logic clk_i, // User clock, 50 MHz
	input wire logic srst_i, // Synchronous reset, active high
	input wire logic ce_i, // Clock enable, freezes state when low
	input wire logic [AV_ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [AV_DATA_W-1:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [AV_DATA_W-1:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall request
	input wire logic command_ready_i, // Controller takes commands
	output logic command_valid_o, // Command request strobe
	output logic [ADDR_W-1:0] command_block_address_o, // Block address
	output logic command_read_mode_o, // 1 read, 0 write command
	input wire logic [PEND_W-1:0] pending_command_count_i, // Incomplete
	input wire logic write_data_ready_i, // Controller takes write data
	output logic write_data_valid_o, // Write beat strobe
	input wire logic read_data_valid_i, // Read beat from controller
	output logic header_queue_pop_o, // Header address taken
	output logic [ADDR_W-1:0] header_address_o // Header block address
);
	ratg_q_if #(.WIDTH(QADDR_W), .LVL_W(BUF_LVL_W)) buf_q ();
	ratg_q_if #(.WIDTH(QADDR_W), .LVL_W(Q_LVL_W)) cmd_q ();
	ratg_q_if #(.WIDTH(QADDR_W), .LVL_W(Q_LVL_W)) hdr_q ();

	logic run_active_ff;
	logic nxt_run_active;
	logic rd_mode_ff;
	logic nxt_rd_mode;
	logic [AV_DATA_W-1:0] addr_lo_ff;
	logic [AV_DATA_W-1:0] nxt_addr_lo;
	logic [ADDR_HI_W-1:0] addr_hi_ff;
	logic [ADDR_HI_W-1:0] nxt_addr_hi;
	logic queue_starved_flag_ff;
	logic nxt_queue_starved_flag;
	logic [CNT_W-1:0] issued_cnt_ff;
	logic [CNT_W-1:0] nxt_issued_cnt;
	logic [AV_DATA_W-1:0] readdata_ff;
	logic rd_done_ff;
	logic rd_valid_d_ff;
	logic [AV_DATA_W-1:0] nxt_readdata;
	logic nxt_rd_done;
	// Commands issued whose header has not been taken yet
	logic [Q_LVL_W-1:0] hdr_owed_ff;
	logic [Q_LVL_W-1:0] nxt_hdr_owed;
	ratg_wstate_type wstate_ff;
	ratg_wstate_type nxt_wstate;
	logic [BEAT_CNT_W-1:0] beat_cnt_ff;
	logic [BEAT_CNT_W-1:0] nxt_beat_cnt;

	// Register bus decode
	wire [AV_DATA_W-1:0] be_mask;
	generate
		for (genvar lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign be_mask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
		end
	endgenerate
	wire sel_ctrl = avs_address == REG_CTRL;
	wire sel_lo = avs_address == REG_ADDR_LO;
	wire sel_hi = avs_address == REG_ADDR_HI;
	wire sel_free = avs_address == REG_FREE;
	wire sel_status = avs_address == REG_STATUS;
	wire sel_comp = avs_address == REG_COMPLETED;
	wire sel_issued = avs_address == REG_ISSUED;
	wire wr_go = avs_write & ce_i;
	wire ctrl_wr = wr_go & sel_ctrl & avs_byteenable[0];
	wire run_start = ctrl_wr & avs_writedata[CTRL_START_BIT];
	wire run_stop = ctrl_wr & avs_writedata[CTRL_STOP_BIT];
	wire hi_wr = wr_go & sel_hi;
	wire lo_wr = wr_go & sel_lo;
	wire read_stall = avs_read & ~rd_done_ff;
	wire write_stall = avs_write & sel_hi & ~buf_q.push_ready;
	// A frozen block holds off every access rather than drop a write
	wire frozen_stall = ~ce_i & (avs_read | avs_write);

	assign avs_waitrequest = read_stall | write_stall | frozen_stall;
	assign avs_readdata = readdata_ff;

	// Full 48-bit address as it will be after this write
	wire [AV_DATA_W-1:0] hi_word = {{(AV_DATA_W-ADDR_HI_W){1'b0}}, addr_hi_ff};
	wire [AV_DATA_W-1:0] hi_merged = (hi_word & ~be_mask) |
		(avs_writedata & be_mask);
	wire [ADDR_W-1:0] new_addr = {hi_merged[ADDR_HI_W-1:0], addr_lo_ff};

	assign nxt_addr_lo = lo_wr ?
		((addr_lo_ff & ~be_mask) | (avs_writedata & be_mask)) : addr_lo_ff;
	assign nxt_addr_hi = hi_wr ? hi_merged[ADDR_HI_W-1:0] : addr_hi_ff;
	assign nxt_rd_mode = run_start ? avs_writedata[CTRL_RDMODE_BIT] :
		rd_mode_ff;
	assign nxt_run_active = run_start | (run_active_ff & ~run_stop);

	// Small staging buffer; a full buffer stalls the bus write
	assign buf_q.push_valid = hi_wr;
	assign buf_q.push_data = new_addr[ADDR_W-1:ALIGN_W];

	ratg_fifo #(.WIDTH(QADDR_W), .DEPTH(BUF_DEPTH)) u_buf (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.q(buf_q)
	);

	// Drain into both queues together so they stay in step,
	// so the header queue never holds fewer words than the command queue
	wire both_ready = cmd_q.push_ready & hdr_q.push_ready;
	assign buf_q.pop_ready = both_ready;
	assign cmd_q.push_valid = buf_q.pop_valid & both_ready;
	assign hdr_q.push_valid = buf_q.pop_valid & both_ready;
	assign cmd_q.push_data = buf_q.pop_data;
	assign hdr_q.push_data = buf_q.pop_data;

	ratg_fifo #(.WIDTH(QADDR_W), .DEPTH(Q_DEPTH)) u_cmd_queue (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.q(cmd_q)
	);

	ratg_fifo #(.WIDTH(QADDR_W), .DEPTH(Q_DEPTH)) u_hdr_queue (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.q(hdr_q)
	);

	// Command control
	// The pop itself is the command strobe; the address rides with it
	wire cmd_queue_empty = ~cmd_q.pop_valid;
	wire header_queue_empty = ~hdr_q.pop_valid;
	wire cmd_queue_pop = run_active_ff & ~cmd_queue_empty &
		command_ready_i;
	assign cmd_q.pop_ready = cmd_queue_pop;
	assign command_valid_o = cmd_queue_pop;
	assign command_block_address_o = {cmd_q.pop_data,
		{ALIGN_W{1'b0}}};
	assign command_read_mode_o = rd_mode_ff;

	// Free space and completion figures
	// Free space trails a bus write by the few cycles of staging
	// Completed count wraps modulo 2^32
	wire [Q_LVL_W-1:0] queue_free_space = Q_DEPTH_LVL - hdr_q.level;
	wire [CNT_W-1:0] completed_command_count = issued_cnt_ff -
		{{(CNT_W-PEND_W){1'b0}}, pending_command_count_i};

	// Starving means the controller waited on an empty queue mid-run
	wire starve_evt = run_active_ff & cmd_queue_empty & command_ready_i;
	assign nxt_queue_starved_flag = (queue_starved_flag_ff & ~run_start) |
		starve_evt;
	assign nxt_issued_cnt = (run_start ? RST_CNT : issued_cnt_ff) +
		{{(CNT_W-1){1'b0}}, cmd_queue_pop};

	// Write data pacing: one header per 128-beat block
	// A header may only follow its own command, never run ahead of it
	wire hdr_allowed = (hdr_owed_ff != '0) | cmd_queue_pop;
	wire wr_run = run_active_ff & ~rd_mode_ff;
	wire wr_hdr_take = wr_run & ~header_queue_empty & write_data_ready_i &
		hdr_allowed;
	wire in_idle = wstate_ff == WS_IDLE;
	wire in_send = wstate_ff == WS_SEND;
	wire wr_hdr_pop = in_idle & wr_hdr_take;
	wire last_beat = beat_cnt_ff == LAST_BEAT;
	assign write_data_valid_o = in_send;

	always_comb begin
		nxt_wstate = wstate_ff;
		nxt_beat_cnt = beat_cnt_ff;
		unique case (wstate_ff)
			WS_IDLE: begin
				nxt_beat_cnt = '0;
				if (wr_hdr_take) begin
					nxt_wstate = WS_SEND;
				end
			end
			WS_SEND: begin
				nxt_beat_cnt = beat_cnt_ff + 1'b1;
				if (last_beat) begin
					nxt_wstate = WS_GAP;
				end
			end
			WS_GAP: begin
				nxt_wstate = WS_IDLE;
			end
			// Illegal codes fall back to idle
			default: begin
				nxt_wstate = WS_IDLE;
			end
		endcase
	end

	// Read blocks: header taken on the first beat of each block
	wire rd_first_beat = read_data_valid_i & ~rd_valid_d_ff;
	wire rd_hdr_pop = run_active_ff & rd_mode_ff & rd_first_beat &
		~header_queue_empty & hdr_allowed;
	wire header_queue_pop = wr_hdr_pop | rd_hdr_pop;
	assign hdr_q.pop_ready = header_queue_pop;
	assign header_queue_pop_o = header_queue_pop;
	assign header_address_o = {hdr_q.pop_data, {ALIGN_W{1'b0}}};

	// Read data mux
	// A read is answered after one wait state from the data register
	wire [AV_DATA_W-1:0] ctrl_word = {{(AV_DATA_W-3){1'b0}},
		1'b0, rd_mode_ff, run_active_ff};
	wire [AV_DATA_W-1:0] status_word = {{(AV_DATA_W-3){1'b0}},
		header_queue_empty, cmd_queue_empty, queue_starved_flag_ff};
	wire [AV_DATA_W-1:0] free_word = {{(AV_DATA_W-Q_LVL_W){1'b0}},
		queue_free_space};
	wire [AV_DATA_W-1:0] rd_mux =
		sel_ctrl ? ctrl_word :
		sel_lo ? addr_lo_ff :
		sel_hi ? hi_word :
		sel_free ? free_word :
		sel_status ? status_word :
		sel_comp ? completed_command_count :
		sel_issued ? issued_cnt_ff :
		RST_WORD;

	assign nxt_readdata = read_stall ? rd_mux : readdata_ff;
	assign nxt_rd_done = read_stall;
	assign nxt_hdr_owed = hdr_owed_ff +
		{{(Q_LVL_W-1){1'b0}}, cmd_queue_pop} -
		{{(Q_LVL_W-1){1'b0}}, header_queue_pop};

	// Every register below holds its value while ce_i is low
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			readdata_ff <= RST_WORD;
		end else if (ce_i) begin
			readdata_ff <= nxt_readdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_done_ff <= 1'b0;
		end else if (ce_i) begin
			rd_done_ff <= nxt_rd_done;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			run_active_ff <= 1'b0;
		end else if (ce_i) begin
			run_active_ff <= nxt_run_active;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_mode_ff <= 1'b0;
		end else if (ce_i) begin
			rd_mode_ff <= nxt_rd_mode;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			addr_lo_ff <= RST_WORD;
		end else if (ce_i) begin
			addr_lo_ff <= nxt_addr_lo;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			addr_hi_ff <= '0;
		end else if (ce_i) begin
			addr_hi_ff <= nxt_addr_hi;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			queue_starved_flag_ff <= 1'b0;
		end else if (ce_i) begin
			queue_starved_flag_ff <= nxt_queue_starved_flag;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			issued_cnt_ff <= RST_CNT;
		end else if (ce_i) begin
			issued_cnt_ff <= nxt_issued_cnt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_valid_d_ff <= 1'b0;
		end else if (ce_i) begin
			rd_valid_d_ff <= read_data_valid_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hdr_owed_ff <= '0;
		end else if (ce_i) begin
			hdr_owed_ff <= nxt_hdr_owed;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wstate_ff <= WS_IDLE;
		end else if (ce_i) begin
			wstate_ff <= nxt_wstate;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			beat_cnt_ff <= '0;
		end else if (ce_i) begin
			beat_cnt_ff <= nxt_beat_cnt;
		end
	end
endmodule

// ### hw/ratg_pkg.sv
// Constants shared by the random-access command generator and its queues.
// Assumes one user clock domain; all offsets are Avalon byte addresses.
package ratg_pkg;
	localparam int ADDR_W = 48;
	localparam int ALIGN_W = 3;
	localparam int QADDR_W = ADDR_W - ALIGN_W;
	localparam int Q_DEPTH = 1024;
	localparam int Q_LVL_W = 11;
	localparam int BUF_DEPTH = 4;
	localparam int BUF_LVL_W = 3;
	localparam int CNT_W = 32;
	localparam int PEND_W = 16;
	localparam int BEAT_CNT_W = 7;
	localparam logic [BEAT_CNT_W-1:0] LAST_BEAT = 7'h7F;
	localparam int AV_ADDR_W = 5;
	localparam int AV_DATA_W = 32;
	localparam logic [AV_ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [AV_ADDR_W-1:0] REG_ADDR_LO = 5'h04;
	localparam logic [AV_ADDR_W-1:0] REG_ADDR_HI = 5'h08;
	localparam logic [AV_ADDR_W-1:0] REG_FREE = 5'h0C;
	localparam logic [AV_ADDR_W-1:0] REG_STATUS = 5'h10;
	localparam logic [AV_ADDR_W-1:0] REG_COMPLETED = 5'h14;
	localparam logic [AV_ADDR_W-1:0] REG_ISSUED = 5'h18;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_RDMODE_BIT = 1;
	localparam int CTRL_STOP_BIT = 2;
	localparam int ADDR_HI_W = 16;
	localparam logic [AV_DATA_W-1:0] RST_WORD = 32'h00000000;
	localparam logic [Q_LVL_W-1:0] Q_DEPTH_LVL = 11'h400;
	localparam logic [CNT_W-1:0] RST_CNT = 32'h00000000;
	typedef enum logic [2:0] {
		WS_IDLE = 3'b001,
		WS_SEND = 3'b010,
		WS_GAP = 3'b100
	} ratg_wstate_type;
endpackage

// ### hw/ratg_q_if.sv
// Push/pop carrier between the generator core and one of its queues.
// Assumes both ends share clk_i; a word moves when valid and ready are high.
`timescale 1ns/100ps
interface ratg_q_if #(
	parameter int WIDTH = 45,
	parameter int LVL_W = 11
);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	logic [LVL_W-1:0] level;
	modport fifo (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, level);
	modport user (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data, level);
endinterface

// ### hw/ratg_mem.sv
// Simple dual-port memory with a registered read port.
// Assumes read-before-write when both ports hit one address on one edge.
`timescale 1ns/100ps
module ratg_mem #(
	parameter int WIDTH = 45,
	parameter int DEPTH = 1024
) (
	input wire logic clk_i, // User clock
	input wire logic srst_i, // Synchronous reset
	input wire logic en_i, // Clock enable
	input wire logic we_i, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] waddr_i, // Write address
	input wire logic [WIDTH-1:0] wdata_i, // Write data
	input wire logic [$clog2(DEPTH)-1:0] raddr_i, // Read address
	output logic [WIDTH-1:0] rdata_o // Registered read data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (en_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o <= '0;
		end else if (en_i) begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

// ### hw/ratg_fifo.sv
// First-word-fall-through FIFO built on ratg_mem.
// Assumes DEPTH is a power of two; a written word shows at the head
// two edges after its push, which keeps the registered read honest.
`timescale 1ns/100ps
module ratg_fifo #(
	parameter int WIDTH = 45,
	parameter int DEPTH = 1024
) (
	input wire logic clk_i, // User clock
	input wire logic srst_i, // Synchronous reset
	input wire logic ce_i, // Clock enable
	ratg_q_if.fifo q // Push and pop ports
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_LVL = (PW + 1)'(DEPTH);
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0] cnt_ff;
	logic wr_d_ff;
	logic [PW:0] occupancy;
	wire push = q.push_valid & q.push_ready;
	wire pop = q.pop_valid & q.pop_ready;
	wire [PW-1:0] rd_addr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;

	assign occupancy = cnt_ff + {{PW{1'b0}}, wr_d_ff};
	assign q.push_ready = ce_i & (occupancy != FULL_LVL);
	assign q.pop_valid = ce_i & (cnt_ff != '0);
	assign q.level = (PW + 1)'(occupancy);

	ratg_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.en_i(ce_i),
		.we_i(push),
		.waddr_i(wr_ptr_ff),
		.wdata_i(q.push_data),
		.raddr_i(rd_addr),
		.rdata_o(q.pop_data)
	);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			wr_d_ff <= 1'b0;
		end else if (ce_i) begin
			wr_ptr_ff <= wr_ptr_ff + {{(PW-1){1'b0}}, push};
			rd_ptr_ff <= rd_addr;
			cnt_ff <= cnt_ff + {{PW{1'b0}}, wr_d_ff} - {{PW{1'b0}}, pop};
			wr_d_ff <= push;
		end
	end
endmodule

// ### tb/ratg_top_chk.sv
// Port-level checks of the command generator.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module ratg_chk
	import ratg_pkg::*;
(
	input wire logic clk_i, // User clock
	input wire logic srst_i, // Reset
	input wire logic ce_i, // Clock enable
	input wire logic command_ready_i, // Controller ready
	input wire logic command_valid_o, // Command strobe
	input wire logic [ADDR_W-1:0] command_block_address_o, // Address
	input wire logic command_read_mode_o, // Read run
	input wire logic read_data_valid_i, // Read beat
	input wire logic write_data_valid_o, // Write beat
	input wire logic header_queue_pop_o, // Header pop
	input wire logic [ADDR_W-1:0] header_address_o // Header address
);
	logic [7:0] run_ff;
	logic [7:0] nxt_run;
	logic [11:0] ahead_ff;
	logic [11:0] nxt_ahead;
	assign nxt_run = write_data_valid_o ? run_ff + 8'h01 : 8'h00;
	assign nxt_ahead = ahead_ff + {11'h000, command_valid_o}
		- {11'h000, header_queue_pop_o};
	always_ff @(posedge clk_i) begin
		run_ff <= srst_i ? 8'h00 : nxt_run;
		ahead_ff <= srst_i ? 12'h000 : nxt_ahead;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	sequence wr_start;
		header_queue_pop_o && !command_read_mode_o;
	endsequence
	sequence rd_first;
		$rose(read_data_valid_i);
	endsequence
	pop_needs_ready_a: assert property (command_valid_o |-> command_ready_i)
		else $error("command issued without ready");
	pop_frozen_a: assert property (!ce_i |-> !command_valid_o)
		else $error("command issued while frozen");
	cmd_align_a: assert property (command_valid_o |->
		command_block_address_o[2:0] == 3'h0)
		else $error("command address not aligned");
	hdr_align_a: assert property (header_queue_pop_o |->
		header_address_o[2:0] == 3'h0)
		else $error("header address not aligned");
	hdr_after_cmd_a: assert property (header_queue_pop_o |->
		ahead_ff != 12'h000 || command_valid_o)
		else $error("header popped before command");
	rd_hdr_pop_a: assert property (header_queue_pop_o && command_read_mode_o
		|-> rd_first)
		else $error("read header pop off the first beat");
	hdr_pulse_a: assert property (header_queue_pop_o |=> !header_queue_pop_o)
		else $error("header pop longer than one cycle");
	wr_burst_a: assert property (wr_start |=> write_data_valid_o[*8])
		else $error("write beats do not follow header pop");
	burst_len_a: assert property ($fell(write_data_valid_o) |->
		run_ff == 8'h80)
		else $error("write block not 128 beats");
	burst_cap_a: assert property (run_ff == 8'h80 |-> !write_data_valid_o)
		else $error("write block over 128 beats");
endmodule
bind ratg_top ratg_chk u_chk (.clk_i, .srst_i, .ce_i, .command_ready_i,
	.command_valid_o, .command_block_address_o, .command_read_mode_o,
	.read_data_valid_i, .write_data_valid_o, .header_queue_pop_o,
	.header_address_o);

// ### tb/ratg_ctl_model.sv
// Storage controller command and data side, behavioural.
// Assumes the bench stalls it through hold_i; reads return 128 beats.
`timescale 1ns/100ps
module ratg_ctl_model
	import ratg_pkg::*;
(
	input wire logic clk_i, // User clock
	input wire logic srst_i, // Reset
	input wire logic hold_i, // Bench stall
	input wire logic command_valid_i, // Command strobe
	input wire logic read_mode_i, // Read run
	input wire logic write_data_valid_i, // Write beat
	output logic command_ready_o, // Takes commands
	output logic write_data_ready_o, // Takes write data
	output logic read_data_valid_o, // Read beat
	output logic [PEND_W-1:0] pending_o // Incomplete commands
);
	logic [6:0] wbeat_ff;
	logic [6:0] rbeat_ff;
	logic [PEND_W-1:0] owed_ff;
	logic wlast;
	logic rlast;
	logic rgo;
	assign wlast = write_data_valid_i && wbeat_ff == 7'h7F;
	assign rlast = read_data_valid_o && rbeat_ff == 7'h7F;
	// A low cycle always separates read blocks
	assign rgo = !read_data_valid_o && owed_ff != 16'h0000 && !hold_i;
	always @(posedge clk_i) begin
		if (srst_i) begin
			command_ready_o <= 1'b0;
			write_data_ready_o <= 1'b0;
			read_data_valid_o <= 1'b0;
			pending_o <= 16'h0000;
			owed_ff <= 16'h0000;
			wbeat_ff <= 7'h00;
			rbeat_ff <= 7'h00;
		end else begin
			command_ready_o <= !hold_i;
			write_data_ready_o <= !hold_i;
			wbeat_ff <= wbeat_ff + {6'h00, write_data_valid_i};
			rbeat_ff <= rbeat_ff + {6'h00, read_data_valid_o};
			read_data_valid_o <= rgo || (read_data_valid_o && !rlast);
			owed_ff <= owed_ff + {15'h0000, command_valid_i && read_mode_i}
				- {15'h0000, rgo};
			pending_o <= pending_o + {15'h0000, command_valid_i}
				- {15'h0000, wlast || rlast};
		end
	end
endmodule

// ### tb/tb_ratg_top.sv
// Self-checking bench for the command generator.
// Assumes the controller model answers commands and data blocks.
`timescale 1ns/100ps
module tb_ratg_top
	import ratg_pkg::*;
;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ce_i = 1'b1;
	logic hold = 1'b1;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic command_ready_i;
	logic command_valid_o;
	logic [47:0] command_block_address_o;
	logic command_read_mode_o;
	logic [15:0] pending_command_count_i;
	logic write_data_ready_i;
	logic write_data_valid_o;
	logic read_data_valid_i;
	logic header_queue_pop_o;
	logic [47:0] header_address_o;
	logic [47:0] cmd_q[$];
	logic [47:0] hdr_q[$];
	logic [31:0] rd;
	int fail_count = 0;
	int num_checks = 0;
	always #10 clk_i = ~clk_i;
	ratg_top u_dut (.clk_i, .srst_i, .ce_i, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .command_ready_i, .command_valid_o,
		.command_block_address_o, .command_read_mode_o,
		.pending_command_count_i, .write_data_ready_i, .write_data_valid_o,
		.read_data_valid_i, .header_queue_pop_o, .header_address_o);
	ratg_ctl_model u_ctl (.clk_i, .srst_i, .hold_i(hold),
		.command_valid_i(command_valid_o), .read_mode_i(command_read_mode_o),
		.write_data_valid_i(write_data_valid_o),
		.command_ready_o(command_ready_i),
		.write_data_ready_o(write_data_ready_i),
		.read_data_valid_o(read_data_valid_i),
		.pending_o(pending_command_count_i));
	always @(negedge clk_i) begin
		if (command_valid_o === 1'b1)
			cmd_q.push_back(command_block_address_o);
		if (header_queue_pop_o === 1'b1)
			hdr_q.push_back(header_address_o);
	end
	function automatic logic [47:0] blk(input int i);
		return 48'h9A5C3E71B2D5 + 48'(i) * 48'h001122334457;
	endfunction
	task chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task av_wr(input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clk_i);
	endtask
	task av_rd(input logic [4:0] a);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk_i);
	endtask
	task push(input logic [47:0] a);
		av_wr(REG_ADDR_LO, a[31:0]);
		av_wr(REG_ADDR_HI, {16'h0000, a[47:32]});
	endtask
	task drain(input int n, input int base, input logic [31:0] ctl);
		do av_rd(REG_COMPLETED); while (rd !== 32'(n));
		av_rd(REG_ISSUED);
		chk(rd, 48'(n));
		av_rd(REG_CTRL);
		chk(rd, 48'(ctl));
		for (int i = 0; i < n; i++) begin
			chk(cmd_q.pop_front(), blk(base + i) & ~48'h7);
			chk(hdr_q.pop_front(), blk(base + i) & ~48'h7);
		end
		av_rd(REG_STATUS);
		chk(rd, 48'h7);
		av_rd(REG_FREE);
		chk(rd, 48'h400);
		av_wr(REG_CTRL, 32'h00000004);
	endtask
	task t_reset;
		av_rd(REG_FREE);
		chk(rd, 48'h400);
		av_rd(REG_STATUS);
		chk(rd, 48'h6);
		av_wr(5'h1C, 32'hFFFFFFFF);
		av_rd(5'h1C);
		chk(rd, 48'h0);
		$display("t_reset done");
	endtask
	task t_write;
		for (int i = 0; i < 4; i++) push(blk(i));
		ce_i <= 1'b0;
		fork
			push(blk(4));
			begin
				repeat (20) @(posedge clk_i);
				chk(avs_waitrequest, 48'h1);
				ce_i <= 1'b1;
			end
		join
		repeat (4) @(posedge clk_i);
		av_rd(REG_FREE);
		chk(rd, 48'h3FB);
		av_wr(REG_CTRL, 32'h00000001);
		chk(command_read_mode_o, 48'h0);
		hold <= 1'b0;
		drain(5, 0, 32'h00000001);
		$display("t_write done");
	endtask
	task t_read;
		hold <= 1'b1;
		av_wr(REG_CTRL, 32'h00000003);
		chk(command_read_mode_o, 48'h1);
		av_rd(REG_STATUS);
		chk(rd, 48'h6);
		av_rd(REG_ISSUED);
		chk(rd, 48'h0);
		push(blk(5));
		push(blk(6));
		hold <= 1'b0;
		drain(2, 5, 32'h00000003);
		$display("t_read done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_write;
		t_read;
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		print_verdict;
	end
endmodule
